// File: dv/adc_link_monitor.sv
// Checker for the signals between the converter end and the host end.
`timescale 1ns/1ns
module adc_link_monitor (
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic        conversion_clock_in,
    input wire logic        conversion_start_n,
    input wire logic        busy,
    input wire logic        cs_n,
    input wire logic        rd_n,
    input wire logic        wr_n,
    input wire logic        word_mode,
    input wire logic [11:0] dev_data_oe_n,
    input wire logic [11:0] host_data_oe_n,
    input wire logic        auto_power_down
);
    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    logic [7:0] sf_cnt_ff;
    logic [7:0] rise_cnt_ff;
    logic [7:0] idle_cnt_ff;
    logic       asleep_ff;

    // Counts from the start fall so rises before busy are not lost.
    always_ff @(posedge clk_sys) begin
        if (!rst_b || $fell(conversion_start_n)) begin
            sf_cnt_ff <= 8'h00;
            rise_cnt_ff <= 8'h00;
        end else begin
            if (sf_cnt_ff != 8'hff) sf_cnt_ff <= sf_cnt_ff + 8'h01;
            if ($rose(conversion_clock_in) && rise_cnt_ff != 8'hff)
                rise_cnt_ff <= rise_cnt_ff + 8'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b || (!cs_n && !rd_n)) idle_cnt_ff <= 8'h00;
        else if (idle_cnt_ff != 8'hff) idle_cnt_ff <= idle_cnt_ff + 8'h01;
    end

    // Mirrors the converter's power state, which the link does not show.
    always_ff @(posedge clk_sys) begin
        if (!rst_b || $rose(conversion_start_n)) begin
            asleep_ff <= 1'b0;
        end else if ($fell(busy) && auto_power_down) begin
            asleep_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    property p_busy_rise;
        $fell(conversion_start_n) && !busy && !asleep_ff |-> ##[1:6] busy;
    endproperty
    a_busy_rise: assert property (p_busy_rise)
        else $error("busy did not rise after start fall");
    property p_busy_cause;
        $rose(busy) |-> sf_cnt_ff <= 8'h06;
    endproperty
    a_busy_cause: assert property (p_busy_cause)
        else $error("busy rose without a start fall");
    property p_busy_stay;
        $rose(busy) |-> busy [*8];
    endproperty
    a_busy_stay: assert property (p_busy_stay)
        else $error("busy dropped early");
    property p_busy_len;
        $fell(busy) |-> rise_cnt_ff >= 8'd13;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("busy fell before thirteen clock rises");
    property p_busy_end;
        $rose(busy) |-> ##[1:300] !busy;
    endproperty
    a_busy_end: assert property (p_busy_end)
        else $error("conversion never finished");
    property p_read_drive;
        $fell(rd_n) && !cs_n && word_mode
            |-> ##[1:6] dev_data_oe_n == 12'h000;
    endproperty
    a_read_drive: assert property (p_read_drive)
        else $error("word read not driven on all lines");
    property p_byte_lines;
        !cs_n && !rd_n && !word_mode |-> dev_data_oe_n[11:8] == 4'hf;
    endproperty
    a_byte_lines: assert property (p_byte_lines)
        else $error("device drove upper lines in byte mode");
    property p_release;
        idle_cnt_ff >= 8'd6 |-> dev_data_oe_n == 12'hfff;
    endproperty
    a_release: assert property (p_release)
        else $error("data lines driven outside a read");
    property p_strobe_cs;
        !rd_n || !wr_n |-> !cs_n;
    endproperty
    a_strobe_cs: assert property (p_strobe_cs)
        else $error("strobe without chip select");
    property p_no_fight;
        !rd_n && word_mode |-> host_data_oe_n == 12'hfff;
    endproperty
    a_no_fight: assert property (p_no_fight)
        else $error("host drove the bus during a read");
    property p_sleep_ignore;
        $fell(conversion_start_n) && asleep_ff |-> !busy [*8];
    endproperty
    a_sleep_ignore: assert property (p_sleep_ignore)
        else $error("converted while powered down");

    c_conv: cover property ($fell(busy));
    c_word_read: cover property ($fell(rd_n) && word_mode);
    c_byte_read: cover property ($fell(rd_n) && !word_mode);
    c_write: cover property ($fell(wr_n));
    c_wake: cover property ($rose(conversion_start_n) && asleep_ff);
endmodule

// File: dv/adc_parallel_conversion_control_tb.sv
// Self-checking bench for the converter end and the host end.
`timescale 1ns/1ns
module adc_parallel_conversion_control_tb;
    logic        clk_sys;
    logic        rst_b;
    logic        word_mode_sel;
    logic        start_req;
    logic        read_req;
    logic        write_req;
    logic        auto_power_down;
    logic [11:0] write_data;
    logic [11:0] sample_value;
    logic        holding_ff;
    logic        powered_ff;
    logic [11:0] control_reg_ff;
    logic [11:0] shadow_reg_ff;
    logic        result_ready_ff;
    logic        ack_ff;
    logic [11:0] read_data_ff;
    logic        busy_seen_ff;
    logic [11:0] ctl [2];
    logic [11:0] smp [2];
    int          miscompares;
    int          tests_run;

    adc_bus_if u_adc_bus_if ();
    adc_device u_adc_device (.clk_sys(clk_sys), .rst_b(rst_b),
        .bus(u_adc_bus_if), .sample_value(sample_value),
        .auto_power_down(auto_power_down), .holding_ff(holding_ff),
        .powered_ff(powered_ff), .control_reg_ff(control_reg_ff),
        .shadow_reg_ff(shadow_reg_ff), .result_ready_ff(result_ready_ff));
    adc_host u_adc_host (.clk_sys(clk_sys), .rst_b(rst_b),
        .bus(u_adc_bus_if), .word_mode_sel(word_mode_sel),
        .start_req(start_req), .read_req(read_req),
        .write_req(write_req), .write_data(write_data), .ack_ff(ack_ff),
        .read_data_ff(read_data_ff), .busy_seen_ff(busy_seen_ff));
    adc_link_monitor u_adc_link_monitor (.clk_sys(clk_sys), .rst_b(rst_b),
        .conversion_clock_in(u_adc_bus_if.conversion_clock_in),
        .conversion_start_n(u_adc_bus_if.conversion_start_n),
        .busy(u_adc_bus_if.busy), .cs_n(u_adc_bus_if.cs_n),
        .rd_n(u_adc_bus_if.rd_n), .wr_n(u_adc_bus_if.wr_n),
        .word_mode(u_adc_bus_if.word_mode),
        .dev_data_oe_n(u_adc_bus_if.dev_data_oe_n),
        .host_data_oe_n(u_adc_bus_if.host_data_oe_n),
        .auto_power_down(auto_power_down));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [11:0] seen,
                         input logic [11:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Kind 0 starts a conversion, 1 reads, 2 writes; all wait for ack, then eight cycles, then for busy low.
    task automatic op(input int kind, input logic [11:0] data);
        int n;
        @(posedge clk_sys);
        #2;
        write_data = data;
        start_req = (kind == 0);
        read_req = (kind == 1);
        write_req = (kind == 2);
        @(posedge clk_sys);
        #2;
        start_req = 1'b0;
        read_req = 1'b0;
        write_req = 1'b0;
        n = 0;
        while (ack_ff !== 1'b1 && n < 400) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        check("ack", {11'h000, ack_ff}, 12'h001);
        // Busy rises a few cycles late, so wait before polling it.
        repeat (8) @(posedge clk_sys);
        n = 0;
        while (u_adc_bus_if.busy !== 1'b0 && n < 300) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        #2;
    endtask

    task automatic close_out;
        $display("Checks run %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog and tests
    // ------------------------------------------------------------
    always #10 clk_sys = ~clk_sys;

    // The tests need under two thousand cycles; twenty thousand is ample.
    initial begin
        #(20 * 20000);
        miscompares++;
        close_out();
    end

    initial begin
        clk_sys = 1'b0;
        rst_b = 1'b0;
        word_mode_sel = 1'b1;
        start_req = 1'b0;
        read_req = 1'b0;
        write_req = 1'b0;
        write_data = 12'h000;
        auto_power_down = 1'b0;
        sample_value = 12'h000;
        miscompares = 0;
        tests_run = 0;
        ctl = '{12'h005, 12'h0a2};
        smp = '{12'ha5c, 12'h3f1};
        repeat (12) @(posedge clk_sys);
        #2;
        rst_b = 1'b1;
        check("idle busy", {11'h000, u_adc_bus_if.busy}, 12'h000);
        check("idle lines", u_adc_bus_if.dev_data_oe_n, 12'hfff);
        for (int i = 0; i < 2; i++) begin
            word_mode_sel = 1'b1;
            op(2, ctl[i]);
            check("control", control_reg_ff, ctl[i]);
            check("shadow", shadow_reg_ff,
                  (i == 0) ? adc_pkg::REG_RESET : ctl[0]);
            sample_value = smp[i];
            op(0, 12'h000);
            check("busy seen", {11'h000, busy_seen_ff}, 12'h001);
            check("ready", {11'h000, result_ready_ff}, 12'h001);
            check("tracking", {11'h000, holding_ff}, 12'h000);
            op(1, 12'h000);
            check("word read", read_data_ff, smp[i]);
            word_mode_sel = 1'b0;
            op(1, 12'h000);
            check("low byte", {4'h0, read_data_ff[7:0]},
                  {4'h0, smp[i][7:0]});
            op(1, 12'h100);
            check("high byte", {5'h00, read_data_ff[6:0]},
                  {5'h00, ctl[i][2:0], smp[i][11:8]});
        end
        // Automatic power-down: sleep after a result, wake on start rise.
        auto_power_down = 1'b1;
        word_mode_sel = 1'b1;
        op(0, 12'h000);
        check("asleep", {11'h000, powered_ff}, 12'h000);
        sample_value = smp[0];
        op(0, 12'h000);
        check("woken", {11'h000, powered_ff}, 12'h001);
        check("no conversion", {11'h000, busy_seen_ff}, 12'h000);
        op(0, 12'h000);
        check("busy after wake", {11'h000, busy_seen_ff}, 12'h001);
        op(1, 12'h000);
        check("read after wake", read_data_ff, smp[0]);
        close_out();
    end
endmodule

// File: hdl/adc_device.sv
// Converter end: conversion sequencing and the parallel data bus.
// Function
// R1 - Start conversion, hold sample on start fall.
// R2 - Busy rises after start fall, stays high.
// R3 - Busy falls only after result loaded.
// R4 - Track resumes on thirteenth conversion clock rise.
// R5 - Conversion takes thirteen clocks plus extra delay.
// R6 - Conversion clock may be continuous or burst.
// R7 - Start rising edge powers up after auto-shutdown.
// R8 - Writes captured only with write and select low.
// R9 - Result driven after read fall under select.
// R10 - Strobes without chip select do nothing.
// R11 - Word mode uses upper lines nine to eleven.
// R12 - Word/byte select picks twelve or eight lines.
// R13 - High byte select steers low or top bits.
// R14 - High byte read carries channel identity.
// R15 - Data lines released unless select and read low.
`timescale 1ns/1ns
module adc_device #(
    parameter int EXTRA = adc_pkg::EXTRA_CYCLES
) (
    input  wire logic                   clk_sys,
    input  wire logic                   rst_b,
    adc_bus_if.device                   bus,
    input  wire logic [11:0]            sample_value,
    input  wire logic                   auto_power_down,
    output logic                        holding_ff,
    output logic                        powered_ff,
    output logic [11:0]                 control_reg_ff,
    output logic [11:0]                 shadow_reg_ff,
    output logic                        result_ready_ff
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [1:0]  cclk_s_ff, start_s_ff, cs_s_ff, rd_s_ff, wr_s_ff, wm_s_ff;
    logic [11:0] d_s1_ff, d_s2_ff;
    logic        cclk_d_ff, start_d_ff, rd_d_ff, wr_d_ff;
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            cclk_s_ff  <= 2'h0;
            start_s_ff <= 2'h3;
            cs_s_ff    <= 2'h3;
            rd_s_ff    <= 2'h3;
            wr_s_ff    <= 2'h3;
            wm_s_ff    <= 2'h3;
            d_s1_ff    <= 12'h000;
            d_s2_ff    <= 12'h000;
            cclk_d_ff  <= 1'b0;
            start_d_ff <= 1'b1;
            rd_d_ff    <= 1'b1;
            wr_d_ff    <= 1'b1;
        end else begin
            cclk_s_ff  <= {cclk_s_ff[0], bus.conversion_clock_in};
            start_s_ff <= {start_s_ff[0], bus.conversion_start_n};
            cs_s_ff    <= {cs_s_ff[0], bus.cs_n};
            rd_s_ff    <= {rd_s_ff[0], bus.rd_n};
            wr_s_ff    <= {wr_s_ff[0], bus.wr_n};
            wm_s_ff    <= {wm_s_ff[0], bus.word_mode};
            d_s1_ff    <= bus.data_bus;
            d_s2_ff    <= d_s1_ff;
            cclk_d_ff  <= cclk_s_ff[1];
            start_d_ff <= start_s_ff[1];
            rd_d_ff    <= rd_s_ff[1];
            wr_d_ff    <= wr_s_ff[1];
        end
    end
    logic cclk_rise, start_fall, start_rise, rd_fall, wr_rise, sel;
    assign cclk_rise  = cclk_s_ff[1] && !cclk_d_ff;
    assign start_fall = !start_s_ff[1] && start_d_ff;
    assign start_rise = start_s_ff[1] && !start_d_ff;
    assign sel        = !cs_s_ff[1];                          // R10
    assign rd_fall    = sel && !rd_s_ff[1] && rd_d_ff;
    assign wr_rise    = sel && wr_s_ff[1] && !wr_d_ff;
    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    typedef enum {S_IDLE, S_CONV, S_EXTRA} conv_state_t;
    conv_state_t state_ff;
    logic [3:0]  edge_cnt_ff;
    logic [7:0]  extra_cnt_ff;
    logic [11:0] result_ff;
    logic [2:0]  chan_ff;
    logic        busy_ff;
    // The sequencer only advances in S_CONV on conversion clock edges, so gaps
    // in a burst clock simply stretch the conversion.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state_ff        <= S_IDLE;
            edge_cnt_ff     <= 4'h0;
            extra_cnt_ff    <= 8'h00;
            busy_ff         <= 1'b0;
            holding_ff      <= 1'b0;
            result_ff       <= adc_pkg::RESULT_RESET;
            result_ready_ff <= 1'b0;
            chan_ff         <= adc_pkg::CHAN_RESET;
        end else begin
            unique case (state_ff)
                S_IDLE: begin
                    if (start_fall && powered_ff) begin
                        state_ff        <= S_CONV;                // R1
                        holding_ff      <= 1'b1;                  // R1
                        busy_ff         <= 1'b1;                  // R2
                        edge_cnt_ff     <= 4'h0;
                        result_ready_ff <= 1'b0;
                        chan_ff <= control_reg_ff[adc_pkg::CHAN_W-1:0];
                    end
                end
                S_CONV: begin
                    if (cclk_rise) begin                          // R6
                        edge_cnt_ff <= edge_cnt_ff + 4'h1;
                        if (edge_cnt_ff == 4'(adc_pkg::CONV_CYCLES - 1)) begin
                            holding_ff   <= 1'b0;                 // R4
                            state_ff     <= S_EXTRA;              // R5
                            extra_cnt_ff <= 8'h00;
                        end
                    end
                end
                S_EXTRA: begin
                    extra_cnt_ff <= extra_cnt_ff + 8'h01;
                    if (extra_cnt_ff == 8'(EXTRA - 1)) begin      // R5
                        result_ff       <= sample_value;
                        result_ready_ff <= 1'b1;
                        busy_ff         <= 1'b0;                  // R3
                        state_ff        <= S_IDLE;
                    end
                end
            endcase
        end
    end
    assign bus.busy = busy_ff;
    // ------------------------------------------------------------
    // Power-up and register writes
    // ------------------------------------------------------------
    // Sleep only once a result is loaded; dropping power whenever idle
    // would undo each wake-up before the next start could follow it.
    logic conv_done;
    assign conv_done = state_ff == S_EXTRA && extra_cnt_ff == 8'(EXTRA - 1);
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            powered_ff <= 1'b1;
        end else if (start_rise) begin
            powered_ff <= 1'b1;                                   // R7
        end else if (auto_power_down && conv_done) begin
            powered_ff <= 1'b0;                                   // R7
        end
    end
    logic [11:0] wdata;
    always_comb begin
        if (wm_s_ff[1]) begin
            wdata = d_s2_ff;                                      // R11
        end else if (d_s2_ff[adc_pkg::HBSEL_BIT]) begin
            wdata = {d_s2_ff[3:0], control_reg_ff[7:0]};          // R13
        end else begin
            wdata = {control_reg_ff[11:8], d_s2_ff[7:0]};         // R12
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            control_reg_ff <= adc_pkg::REG_RESET;
            shadow_reg_ff  <= adc_pkg::REG_RESET;
        end else if (wr_rise) begin                               // R8
            control_reg_ff <= wdata;
            shadow_reg_ff  <= control_reg_ff;
        end
    end
    // ------------------------------------------------------------
    // Read data drive
    // ------------------------------------------------------------
    logic [11:0] dout_ff, doe_n_ff;
    logic        reading_ff;
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            reading_ff <= 1'b0;
        end else if (rd_fall) begin
            reading_ff <= 1'b1;                                   // R9
        end else if (!sel || rd_s_ff[1]) begin
            reading_ff <= 1'b0;                                   // R15
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            dout_ff  <= 12'h000;
            doe_n_ff <= 12'hFFF;
        end else if (rd_fall || (reading_ff && sel && !rd_s_ff[1])) begin
            if (wm_s_ff[1]) begin
                dout_ff  <= result_ff;                            // R11
                doe_n_ff <= 12'h000;
            end else if (d_s2_ff[adc_pkg::HBSEL_BIT]) begin
                dout_ff  <= {5'h00, chan_ff, result_ff[11:8]};    // R14
                doe_n_ff <= 12'hF00;
            end else begin
                dout_ff  <= {4'h0, result_ff[7:0]};               // R13
                doe_n_ff <= 12'hF00;
            end
        end else begin
            doe_n_ff <= 12'hFFF;                                  // R15
        end
    end
    assign bus.dev_data_out  = dout_ff;
    assign bus.dev_data_oe_n = doe_n_ff;
endmodule

// File: hdl/adc_host.sv
// Host end: starts conversions and runs reads and writes on the bus.
`timescale 1ns/1ns
module adc_host #(
    parameter int CLK_DIV = 4
) (
    input  wire logic                   clk_sys,
    input  wire logic                   rst_b,
    adc_bus_if.host                     bus,
    input  wire logic                   word_mode_sel,
    input  wire logic                   start_req,
    input  wire logic                   read_req,
    input  wire logic                   write_req,
    input  wire logic [11:0]            write_data,
    output logic                        ack_ff,
    output logic [11:0]                 read_data_ff,
    output logic                        busy_seen_ff
);
    // ------------------------------------------------------------
    // Conversion clock divider, free running (R6)
    // ------------------------------------------------------------
    logic [7:0] div_ff;
    logic       cclk_ff;
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            div_ff  <= 8'h00;
            cclk_ff <= 1'b0;
        end else if (div_ff == 8'(CLK_DIV - 1)) begin
            div_ff  <= 8'h00;
            cclk_ff <= !cclk_ff;
        end else begin
            div_ff <= div_ff + 8'h01;
        end
    end
    logic [1:0] busy_s_ff;
    logic [11:0] d_s1_ff, d_s2_ff;
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            busy_s_ff <= 2'h0;
            d_s1_ff   <= 12'h000;
            d_s2_ff   <= 12'h000;
        end else begin
            busy_s_ff <= {busy_s_ff[0], bus.busy};
            d_s1_ff   <= bus.data_bus;
            d_s2_ff   <= d_s1_ff;
        end
    end
    // ------------------------------------------------------------
    // Bus sequencer
    // ------------------------------------------------------------
    typedef enum {H_IDLE, H_START, H_STROBE, H_HOLD, H_DONE} host_state_t;
    host_state_t st_ff;
    logic [3:0]  cnt_ff;
    logic        is_rd_ff, is_wr_ff, cs_ff, rd_ff, wr_ff, cv_ff;
    logic [11:0] hout_ff, hoe_n_ff;
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            st_ff        <= H_IDLE;
            cnt_ff       <= 4'h0;
            is_rd_ff     <= 1'b0;
            is_wr_ff     <= 1'b0;
            cs_ff        <= 1'b1;
            rd_ff        <= 1'b1;
            wr_ff        <= 1'b1;
            cv_ff        <= 1'b1;
            hout_ff      <= 12'h000;
            hoe_n_ff     <= 12'hFFF;
            ack_ff       <= 1'b0;
            read_data_ff <= 12'h000;
            busy_seen_ff <= 1'b0;
        end else begin
            ack_ff       <= 1'b0;
            if (busy_s_ff[1]) begin
                busy_seen_ff <= 1'b1;
            end
            cnt_ff       <= cnt_ff + 4'h1;
            unique case (st_ff)
                H_IDLE: begin
                    cnt_ff <= 4'h0;
                    if (start_req) begin
                        cv_ff <= 1'b0;
                        busy_seen_ff <= 1'b0;
                        st_ff <= H_START;
                    end else if (read_req || write_req) begin
                        is_rd_ff <= read_req;
                        is_wr_ff <= !read_req;
                        cs_ff    <= 1'b0;                         // R10
                        hout_ff  <= write_data;
                        if (!word_mode_sel && write_data[8]) begin
                            hout_ff[7:4] <= 4'h0;                 // R14
                        end
                        hoe_n_ff <= word_mode_sel ? 12'h000 : 12'hE00;
                        // A byte read still drives the high byte select.
                        if (read_req) begin                       // R13
                            hoe_n_ff <= word_mode_sel ? 12'hFFF : 12'hEFF;
                        end
                        st_ff    <= H_STROBE;
                    end
                end
                H_START: begin
                    if (cnt_ff == 4'h7) begin
                        cv_ff <= 1'b1;                            // R7
                        st_ff <= H_DONE;
                    end
                end
                H_STROBE: begin
                    rd_ff  <= !is_rd_ff;
                    wr_ff  <= !is_wr_ff;                          // R8
                    cnt_ff <= 4'h0;
                    st_ff  <= H_HOLD;
                end
                H_HOLD: begin
                    if (cnt_ff == 4'hF) begin
                        if (is_rd_ff) begin
                            read_data_ff <= d_s2_ff;
                        end
                        rd_ff <= 1'b1;
                        wr_ff <= 1'b1;
                        st_ff <= H_DONE;
                    end
                end
                H_DONE: begin
                    cs_ff    <= 1'b1;
                    hoe_n_ff <= 12'hFFF;
                    ack_ff   <= 1'b1;
                    st_ff    <= H_IDLE;
                end
            endcase
        end
    end
    assign bus.conversion_clock_in = cclk_ff;
    assign bus.conversion_start_n  = cv_ff;
    assign bus.cs_n                = cs_ff;
    assign bus.rd_n                = rd_ff;
    assign bus.wr_n                = wr_ff;
    assign bus.word_mode           = word_mode_sel;
    assign bus.host_data_out       = hout_ff;
    assign bus.host_data_oe_n      = hoe_n_ff;
endmodule

// File: include/adc_bus_if.sv
// Interface joining the converter end and the host end.
`timescale 1ns/1ns
interface adc_bus_if;
    logic        conversion_clock_in;
    logic        conversion_start_n;
    logic        busy;
    logic        cs_n;
    logic        rd_n;
    logic        wr_n;
    logic        word_mode;
    logic [11:0] dev_data_out;
    logic [11:0] dev_data_oe_n;
    logic [11:0] host_data_out;
    logic [11:0] host_data_oe_n;
    wire  [11:0] data_bus;
    genvar i;
    for (i = 0; i < 12; i++) begin : g_bus
        assign data_bus[i] = !dev_data_oe_n[i] ? dev_data_out[i] :
                             !host_data_oe_n[i] ? host_data_out[i] : 1'b0;
    end
    modport device (
        input  conversion_clock_in, conversion_start_n, cs_n, rd_n, wr_n,
        input  word_mode, data_bus,
        output busy, dev_data_out, dev_data_oe_n
    );
    modport host (
        output conversion_clock_in, conversion_start_n, cs_n, rd_n, wr_n,
        output word_mode, host_data_out, host_data_oe_n,
        input  busy, data_bus
    );
endinterface

// File: include/adc_pkg.sv
// Shared constants for the converter control link.
package adc_pkg;
    localparam int                  DATA_W          = 12;
    localparam int                  CHAN_W          = 3;
    localparam int                  CONV_CYCLES     = 13;
    localparam int                  EXTRA_DELAY_NS  = 40;
    localparam int                  CLK_PERIOD_NS   = 20;
    localparam int                  EXTRA_CYCLES    =
        (EXTRA_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int                  REG_W           = 12;
    localparam logic [11:0]         REG_RESET       = 12'h000;
    localparam logic [11:0]         RESULT_RESET    = 12'h000;
    localparam int                  LOW_BYTE_LSB    = 0;
    localparam int                  HIGH_NIB_LSB    = 8;
    localparam int                  ID_LSB          = 4;
    localparam int                  UPPER_LSB       = 9;
    localparam int                  HBSEL_BIT       = 8;
    localparam logic [2:0]          CHAN_RESET      = 3'h0;
endpackage
